//--- src/dmn_cfg.svh
/*
  Constants of the deadman timer clear and status block: register
  indices, key patterns, status bit positions and widths.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DMN_CFG_SVH
`define DMN_CFG_SVH

// Avalon byte address width and word-index field
`define DMN_ADDR_W 6
`define DMN_IDX_LSB 2
`define DMN_IDX_MSB 4
`define DMN_HOLE_BIT 5

// Register word indices
`define DMN_IDX_CLR 3'h0
`define DMN_IDX_STAT 3'h1
`define DMN_IDX_CNTL 3'h2
`define DMN_IDX_CNTH 3'h3
`define DMN_IDX_PSCNTL 3'h4
`define DMN_IDX_PSCNTH 3'h5
`define DMN_IDX_PSINTVL 3'h6
`define DMN_IDX_PSINTVH 3'h7

// Key patterns
`define DMN_KEY_FIRST 8'h40
`define DMN_KEY_SECOND 8'h08
`define DMN_KEY_ZERO 8'h00

// Status bit positions
`define DMN_ST_BAD_FIRST_KEY_FLAG 7
`define DMN_ST_BAD_SECOND_KEY_FLAG 6
`define DMN_ST_EVENT 5
`define DMN_ST_WIN 0

// Widths and reset values
`define DMN_CNT_W 32
`define DMN_HALF_W 16
`define DMN_HALF_ZERO 16'h0000
`define DMN_WORD_ZERO 32'h0000_0000

`endif

//--- src/dmn_pkg.sv
/*
  Types shared by the deadman timer clear and status block.
  Assumes dmn_cfg.svh is available on the include path.
*/
`include "dmn_cfg.svh"

package dmn_pkg;

  typedef logic [`DMN_HALF_W-1:0] dmn_half_t;
  typedef logic [`DMN_CNT_W-1:0] dmn_word_t;
  typedef logic [7:0] dmn_key_t;
  typedef logic [2:0] dmn_idx_t;

  // Avalon slave handshake states
  typedef enum logic {AVS_IDLE, AVS_ACK} dmn_avs_e;

endpackage

//--- src/dmn_ifs.sv
/*
  Interfaces between the core and its two helpers: the register
  strobe link from the Avalon slave, and the counter link.
  Assumes dmn_pkg is compiled first.
*/
`timescale 1ns/1ps

interface dmn_reg_if;
  import dmn_pkg::*;
  logic wr_stb;
  logic rd_stb;
  logic hit;
  dmn_idx_t idx;
  logic be_low;
  dmn_half_t wdata;
  dmn_half_t rdata;
  modport slave (output wr_stb, rd_stb, hit, idx, be_low, wdata,
    input rdata);
  modport core (input wr_stb, rd_stb, hit, idx, be_low, wdata,
    output rdata);
endinterface

interface dmn_cnt_if;
  import dmn_pkg::*;
  logic enable;
  logic fetch;
  logic sleep;
  logic clear;
  logic capture;
  dmn_word_t match;
  dmn_word_t interval;
  dmn_word_t count;
  dmn_half_t held;
  logic window_open;
  logic expire;
  logic expired;
  modport core (output enable, fetch, sleep, clear, capture, match,
    interval, input count, held, window_open, expire, expired);
  modport counter (input enable, fetch, sleep, clear, capture, match,
    interval, output count, held, window_open, expire, expired);
endinterface

//--- src/dmn_counter.sv
/*
  Deadman counter: 32-bit fetch counter with count match, clear
  window flag and upper-half hold register.
  Assumes all control comes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "dmn_cfg.svh"

module dmn_counter
  import dmn_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the core
  dmn_cnt_if.counter cnt
);

  dmn_word_t count;
  dmn_word_t next_count;
  dmn_half_t held;
  logic expired;
  logic inc_ok;
  dmn_word_t count_inc;

  // Advance only on a fetch, awake, enabled and before expiry
  assign inc_ok = cnt.enable & cnt.fetch & ~cnt.sleep & ~expired;
  assign count_inc = count + 32'h0000_0001;
  assign next_count = cnt.clear ? `DMN_WORD_ZERO
    : (inc_ok ? count_inc : count);
  assign cnt.expire = inc_ok & (count_inc == cnt.match);
  assign cnt.count = count;
  assign cnt.held = held;
  assign cnt.expired = expired;
  assign cnt.window_open = cnt.enable & ~expired
    & (count >= cnt.interval);

  // Counter and expiry latch
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= `DMN_WORD_ZERO;
      expired <= 1'b0;
    end
    else
    begin
      count <= next_count;
      expired <= expired | cnt.expire;
    end
  end

  // Hold register catches the upper half on a counter read
  always_ff @(posedge clk)
  begin
    if (rst)
      held <= `DMN_HALF_ZERO;
    else if (cnt.capture)
      held <= count[`DMN_CNT_W-1:`DMN_HALF_W];
  end

  AST_NO_STRAY_COUNT:
    assert property (@(posedge clk) disable iff (rst)
      (!cnt.clear && !(cnt.fetch && !cnt.sleep && cnt.enable))
      |=> $stable(count))
    else $error("counter moved without an awake fetch");

  AST_HOLD_CAPTURE:
    assert property (@(posedge clk) disable iff (rst)
      cnt.capture |=> held == $past(count[31:16]))
    else $error("hold register missed the upper half");

endmodule

//--- src/dmn_avs.sv
/*
  Avalon-MM slave front end: one wait state per access, registered
  read data, strobes to the core on the accepting edge.
  Assumes a master that holds its request until waitrequest is low.
*/
`timescale 1ns/1ps
`include "dmn_cfg.svh"

module dmn_avs
  import dmn_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [`DMN_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Strobes to the core
  dmn_reg_if.slave rif
);

  dmn_avs_e state;
  dmn_avs_e next_state;
  logic req;
  logic take;

  // Request decode; top address bit set is the unmapped hole
  assign req = avs_read | avs_write;
  assign take = req & (state == AVS_ACK);
  assign avs_waitrequest = req & (state != AVS_ACK);
  assign rif.wr_stb = avs_write & take;
  assign rif.rd_stb = avs_read & take;
  assign rif.hit = ~avs_address[`DMN_HOLE_BIT];
  assign rif.idx = avs_address[`DMN_IDX_MSB:`DMN_IDX_LSB];
  assign rif.be_low = avs_byteenable[0];
  assign rif.wdata = avs_writedata[`DMN_HALF_W-1:0];

  // One wait state, then accept
  always_comb
  begin
    next_state = state;
    case (state)
      AVS_IDLE: if (req) next_state = AVS_ACK;
      AVS_ACK: next_state = AVS_IDLE;
      default: next_state = AVS_IDLE;
    endcase
  end

  // State and read data; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= AVS_IDLE;
      avs_readdata <= `DMN_WORD_ZERO;
    end
    else
    begin
      state <= next_state;
      if (state == AVS_IDLE && avs_read)
        avs_readdata <= {`DMN_HALF_ZERO,
          (rif.hit ? rif.rdata : `DMN_HALF_ZERO)};
    end
  end

endmodule

//--- src/dmn_top.sv
/*
  Deadman timer clear and status block: two-step key clear, bad key
  and event flags, live counter and configuration readback.
  Assumes the first-step key write port, enable and fuse values sit
  outside on the same clock; software uses the Avalon-MM port.
*/
`timescale 1ns/1ps
`include "dmn_cfg.svh"

// Function
// - Correct second key after correct first key clears keys, restarts counter.
// - After a clear, counter readback shows zero.
// - Wrong second key sets bad flag, keeps first key, stores value.
// - Second key field returns to zero on a deadman reset event.
// - Status bit 7 reports a bad first key, read-only, reset zero.
// - Status bit 6 reports a bad second key, read-only, reset zero.
// - Status bit 5 reports expiry or a bad key.
// - Status bit 0 shows the open clear window.
// - Counter low and high registers return live counter halves.
// - Count status registers mirror the configured count fuses.
// - Interval status registers mirror the configured interval fuses.
// - First key 0x40 arms the clear; other values set bad flag.
// - Counter advances only on awake instruction fetches until match.
// - Hold register catches upper half on counter reads, resets zero.
module dmn_top
  import dmn_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [`DMN_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Processor side
  input wire logic module_enable,
  input wire logic instr_fetch,
  input wire logic cpu_sleep,
  // First-step key write port from outside, key field out
  input wire logic first_key_wr,
  input wire logic [7:0] first_key_wdata,
  output logic [7:0] first_key_field,
  // Fuse values
  input wire logic [15:0] count_fuse_low,
  input wire logic [15:0] count_fuse_high,
  input wire logic [15:0] interval_fuse_low,
  input wire logic [15:0] interval_fuse_high,
  // Hold register and reset request
  output logic [15:0] held_upper_count,
  output logic hold_capture,
  output logic deadman_reset_req
);

  dmn_reg_if rif ();
  dmn_cnt_if cnt ();

  dmn_key_t second_key_field;
  dmn_key_t next_first_key;
  dmn_key_t next_second_key;
  logic bad_first_key_flag;
  logic bad_second_key_flag;
  logic deadman_event_flag;
  logic clear_window_open;
  logic wr_clear_reg;
  dmn_key_t wkey;
  logic armed;
  logic good_clear;
  logic bad_first_set;
  logic bad_second_set;
  logic event_set;
  logic reset_event;
  logic rd_counter;
  dmn_half_t status_word;
  dmn_half_t rd_mux;

  // Register bus front end
  dmn_avs u_avs (
    .clk(clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rif(rif)
  );

  // Fetch counter
  dmn_counter u_counter (
    .clk(clk),
    .rst(rst),
    .cnt(cnt)
  );

  // Counter controls and configured values
  assign cnt.enable = module_enable;
  assign cnt.fetch = instr_fetch;
  assign cnt.sleep = cpu_sleep;
  assign cnt.clear = good_clear;
  assign cnt.capture = rd_counter;
  assign cnt.match = {count_fuse_high, count_fuse_low};
  assign cnt.interval = {interval_fuse_high, interval_fuse_low};

  // Key decode
  assign wr_clear_reg = rif.wr_stb & rif.hit & rif.be_low
    & (rif.idx == `DMN_IDX_CLR);
  assign wkey = rif.wdata[7:0];
  assign armed = (first_key_field == `DMN_KEY_FIRST);
  assign good_clear = wr_clear_reg & armed
    & (wkey == `DMN_KEY_SECOND);
  assign bad_second_set = wr_clear_reg & ~good_clear;
  assign bad_first_set = first_key_wr
    & (first_key_wdata != `DMN_KEY_FIRST);
  assign reset_event = cnt.expire;
  assign event_set = reset_event | bad_first_set | bad_second_set;
  assign clear_window_open = cnt.window_open;
  assign deadman_reset_req = cnt.expired;
  assign held_upper_count = cnt.held;
  assign hold_capture = rd_counter;
  assign rd_counter = rif.rd_stb & rif.hit
    & ((rif.idx == `DMN_IDX_CNTL) | (rif.idx == `DMN_IDX_CNTH));

  // Next key values: reset event, then good clear, then a write
  assign next_first_key = reset_event ? `DMN_KEY_ZERO
    : good_clear ? `DMN_KEY_ZERO
    : first_key_wr ? first_key_wdata : first_key_field;
  assign next_second_key = reset_event ? `DMN_KEY_ZERO
    : good_clear ? `DMN_KEY_ZERO
    : bad_second_set ? wkey : second_key_field;

  // Key fields
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      first_key_field <= `DMN_KEY_ZERO;
      second_key_field <= `DMN_KEY_ZERO;
    end
    else
    begin
      first_key_field <= next_first_key;
      second_key_field <= next_second_key;
    end
  end

  // Sticky status flags; only reset clears them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bad_first_key_flag <= 1'b0;
      bad_second_key_flag <= 1'b0;
      deadman_event_flag <= 1'b0;
    end
    else
    begin
      bad_first_key_flag <= bad_first_key_flag | bad_first_set;
      bad_second_key_flag <= bad_second_key_flag | bad_second_set;
      deadman_event_flag <= deadman_event_flag | event_set;
    end
  end

  // Status word; unused bits read zero
  always_comb
  begin
    status_word = `DMN_HALF_ZERO;
    status_word[`DMN_ST_BAD_FIRST_KEY_FLAG] = bad_first_key_flag;
    status_word[`DMN_ST_BAD_SECOND_KEY_FLAG] = bad_second_key_flag;
    status_word[`DMN_ST_EVENT] = deadman_event_flag;
    status_word[`DMN_ST_WIN] = clear_window_open;
  end

  // Read selection; all registers are read-only apart from the key
  always_comb
  begin
    case (rif.idx)
      `DMN_IDX_CLR: rd_mux = {8'h00, second_key_field};
      `DMN_IDX_STAT: rd_mux = status_word;
      `DMN_IDX_CNTL: rd_mux = cnt.count[15:0];
      `DMN_IDX_CNTH: rd_mux = cnt.count[31:16];
      `DMN_IDX_PSCNTL: rd_mux = count_fuse_low;
      `DMN_IDX_PSCNTH: rd_mux = count_fuse_high;
      `DMN_IDX_PSINTVL: rd_mux = interval_fuse_low;
      `DMN_IDX_PSINTVH: rd_mux = interval_fuse_high;
      default: rd_mux = `DMN_HALF_ZERO;
    endcase
  end
  assign rif.rdata = rd_mux;

  AST_CLEAR_RESTART:
    assert property (@(posedge clk) disable iff (rst)
      (wr_clear_reg && wkey == 8'h08 && first_key_field == 8'h40)
      |=> (cnt.count == 32'h0 && first_key_field == 8'h00
        && second_key_field == 8'h00))
    else $error("good key pair did not restart the counter");

  AST_READ_AFTER_CLEAR:
    assert property (@(posedge clk) disable iff (rst)
      (good_clear ##1 !instr_fetch
        ##1 (avs_read && avs_waitrequest && rif.idx == 3'h2))
      |-> rd_mux == 16'h0000)
    else $error("counter readback not zero after clear");

  AST_BAD_SECOND:
    assert property (@(posedge clk) disable iff (rst)
      (wr_clear_reg && !reset_event && !first_key_wr
        && !(wkey == 8'h08 && first_key_field == 8'h40))
      |=> (bad_second_key_flag
        && first_key_field == $past(first_key_field)
        && second_key_field == $past(wkey)))
    else $error("bad second key handled wrongly");

  AST_EVENT_CLEARS_KEY:
    assert property (@(posedge clk) disable iff (rst)
      cnt.expire |=> second_key_field == 8'h00)
    else $error("second key kept across a reset event");

  AST_BAD_FIRST:
    assert property (@(posedge clk) disable iff (rst)
      (first_key_wr && first_key_wdata != 8'h40)
      |=> (status_word[7] && deadman_event_flag)[*2])
    else $error("bad first key not reported");

  AST_BAD_SECOND_KEY_FLAG_STICKY:
    assert property (@(posedge clk) disable iff (rst)
      status_word[6] |=> status_word[6])
    else $error("bad second key flag fell without reset");

  AST_EXPIRY_EVENT:
    assert property (@(posedge clk) disable iff (rst)
      cnt.expire |=> status_word[5] && deadman_reset_req)
    else $error("expiry not flagged");

  AST_WINDOW_BIT:
    assert property (@(posedge clk) disable iff (rst)
      status_word[0] == (module_enable && !cnt.expired
        && cnt.count >= {interval_fuse_high, interval_fuse_low}))
    else $error("window bit disagrees with the counter");

  AST_COUNT_HIGH_READ:
    assert property (@(posedge clk) disable iff (rst)
      (avs_read && !avs_waitrequest && avs_address == 6'h0c)
      |-> avs_readdata[15:0] == $past(cnt.count[31:16]))
    else $error("counter high read not live");

  AST_COUNT_FUSE:
    assert property (@(posedge clk) disable iff (rst)
      (rif.idx == 3'h5) |-> rd_mux == count_fuse_high)
    else $error("count status does not mirror fuse");

  AST_INTERVAL_FUSE:
    assert property (@(posedge clk) disable iff (rst)
      (avs_read && !avs_waitrequest && avs_address == 6'h18)
      |-> avs_readdata == {16'h0000, $past(interval_fuse_low)})
    else $error("interval status does not mirror fuse");

  AST_ARM:
    assert property (@(posedge clk) disable iff (rst)
      (first_key_wr && first_key_wdata == 8'h40 && !cnt.expire
        && !good_clear && !bad_first_key_flag)
      |=> armed && !bad_first_key_flag)
    else $error("good first key did not arm");

  AST_RESET_REQ_HOLDS:
    assert property (@(posedge clk) disable iff (rst)
      deadman_reset_req |=> deadman_reset_req [*3])
    else $error("reset request dropped");

  AST_COUNT_LOW_READ:
    assert property (@(posedge clk) disable iff (rst)
      (avs_read && !avs_waitrequest && avs_address == 6'h08)
      |-> avs_readdata[15:0] == $past(cnt.count[15:0]))
    else $error("counter low read not live");

  AST_HOLD_PULSE:
    assert property (@(posedge clk) disable iff (rst)
      (avs_read && !avs_waitrequest
        && (avs_address == 6'h08 || avs_address == 6'h0c))
      |-> hold_capture)
    else $error("counter read did not pulse the hold capture");

  AST_COUNT_FUSE_LOW:
    assert property (@(posedge clk) disable iff (rst)
      (avs_read && !avs_waitrequest && avs_address == 6'h10)
      |-> avs_readdata == {16'h0000, $past(count_fuse_low)})
    else $error("count status low does not mirror fuse");

  AST_INTERVAL_FUSE_HIGH:
    assert property (@(posedge clk) disable iff (rst)
      (avs_read && !avs_waitrequest && avs_address == 6'h1c)
      |-> avs_readdata == {16'h0000, $past(interval_fuse_high)})
    else $error("interval status high does not mirror fuse");

  AST_REQ_ONLY_ON_EXPIRY:
    assert property (@(posedge clk) disable iff (rst)
      (!cnt.expire && !deadman_reset_req) |=> !deadman_reset_req)
    else $error("reset request raised without a count match");

  AST_EVENT_CLEARS_FIRST:
    assert property (@(posedge clk) disable iff (rst)
      cnt.expire |=> first_key_field == 8'h00)
    else $error("first key kept across a reset event");

endmodule

//--- tb/dmn_top_tb.sv
/*
  Self-checking bench for the deadman timer clear and status block.
  Assumes the design files and dmn_cfg.svh are compiled before it.
*/
`timescale 1ns/1ps
`include "dmn_cfg.svh"

module dmn_top_tb;
  import dmn_pkg::*;
  // Design stimulus, all given a value at time zero
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic module_enable = 1'b0;
  logic instr_fetch = 1'b0;
  logic cpu_sleep = 1'b0;
  logic first_key_wr = 1'b0;
  logic [7:0] first_key_wdata = 8'h00;
  logic [15:0] count_fuse_low = 16'h1234;
  logic [15:0] count_fuse_high = 16'h5678;
  logic [15:0] interval_fuse_low = 16'h9abc;
  logic [15:0] interval_fuse_high = 16'hdef0;
  // Design outputs
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] first_key_field;
  logic [15:0] held_upper_count;
  logic hold_capture;
  logic deadman_reset_req;
  int n_errors = 0;
  int total_checks = 0;
  int n_caps = 0;
  logic [15:0] fuse_exp [4];

  // 100 MHz clock
  always #5 clk = ~clk;

  // Counts cycles in which the hold capture strobe is high
  always @(posedge clk)
  begin
    if (hold_capture === 1'b1)
      n_caps <= n_caps + 1;
  end

  dmn_top dmn_top_i (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .module_enable(module_enable), .instr_fetch(instr_fetch),
    .cpu_sleep(cpu_sleep), .first_key_wr(first_key_wr),
    .first_key_wdata(first_key_wdata), .first_key_field(first_key_field),
    .count_fuse_low(count_fuse_low), .count_fuse_high(count_fuse_high),
    .interval_fuse_low(interval_fuse_low),
    .interval_fuse_high(interval_fuse_high),
    .held_upper_count(held_upper_count), .hold_capture(hold_capture),
    .deadman_reset_req(deadman_reset_req)
  );

  // Prints the verdict and ends the run
  task automatic final_report();
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One comparison with four-state equality
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
        got, exp);
    end
  endtask

  // Byte address of a register word index
  function automatic logic [5:0] ad(input dmn_idx_t i);
    return {1'b0, i, 2'b00};
  endfunction

  // One Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] addr,
    input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= addr;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    // Right after an edge the bus still shows its pre-edge values
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      n_errors++;
      $display("wrong value at %0t: no answer on the bus", $time);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Read and compare one register
  task automatic rd_chk(input logic [5:0] addr, input logic [31:0] exp,
    input string what);
    logic [31:0] d;
    bus(1'b0, addr, 32'h0000_0000, 4'hf, d);
    chk(d, exp, what);
  endtask

  // Write one register
  task automatic wr(input logic [5:0] addr, input logic [31:0] wd,
    input logic [3:0] be);
    logic [31:0] d;
    bus(1'b1, addr, wd, be, d);
  endtask

  // One-cycle write pulse on the first-step key port
  task automatic key1(input logic [7:0] v);
    @(posedge clk);
    first_key_wr <= 1'b1;
    first_key_wdata <= v;
    @(posedge clk);
    first_key_wr <= 1'b0;
  endtask

  // Fetch for n cycles, with sleep held at the given level
  task automatic fetch(input int n, input logic slp);
    @(posedge clk);
    instr_fetch <= 1'b1;
    cpu_sleep <= slp;
    repeat (n) @(posedge clk);
    instr_fetch <= 1'b0;
    cpu_sleep <= 1'b0;
  endtask

  // Synchronous reset held for 20 cycles
  task automatic do_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // Cuts a hang short
  initial
  begin
    #200000;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial
  begin
    fuse_exp = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
    do_rst();
    rd_chk(ad(`DMN_IDX_STAT), 32'h0, "status after reset");
    rd_chk(ad(`DMN_IDX_CNTH), 32'h0, "count high at reset");
    chk({16'h0, held_upper_count}, 32'h0, "hold at reset");
    for (int i = 0; i < 4; i++)
      rd_chk(ad(dmn_idx_t'(4 + i)), {16'h0, fuse_exp[i]}, "fuse");
    // Small match and interval so expiry is reached quickly
    count_fuse_low <= 16'h0030;
    count_fuse_high <= 16'h0000;
    interval_fuse_low <= 16'h0010;
    interval_fuse_high <= 16'h0000;
    module_enable <= 1'b1;
    do_rst();
    fetch(5, 1'b1);
    module_enable <= 1'b0;
    fetch(3, 1'b0);
    module_enable <= 1'b1;
    fetch(7, 1'b0);
    rd_chk(ad(`DMN_IDX_CNTL), 32'h7, "count gated");
    rd_chk(ad(`DMN_IDX_STAT), 32'h0, "window shut");
    fetch(12, 1'b0);
    rd_chk(ad(`DMN_IDX_STAT), 32'h1, "window open");
    rd_chk(ad(`DMN_IDX_CNTH), 32'h0, "count high");
    chk({16'h0, held_upper_count}, 32'h0, "hold after read");
    // Two-step clear
    key1(`DMN_KEY_FIRST);
    wr(ad(`DMN_IDX_CLR), 32'h08, 4'hf);
    rd_chk(ad(`DMN_IDX_CNTL), 32'h0, "count after clear");
    rd_chk(ad(`DMN_IDX_CLR), 32'h0, "second key after clear");
    chk({24'h0, first_key_field}, 32'h0, "first key after clear");
    // Masked key write and status write are ignored
    key1(`DMN_KEY_FIRST);
    wr(ad(`DMN_IDX_CLR), 32'h55, 4'he);
    rd_chk(ad(`DMN_IDX_CLR), 32'h0, "masked key write");
    wr(ad(`DMN_IDX_STAT), 32'hffff, 4'hf);
    rd_chk(ad(`DMN_IDX_STAT), 32'h0, "status read-only");
    rd_chk(6'h24, 32'h0, "unmapped read");
    // Wrong second key while armed
    wr(ad(`DMN_IDX_CLR), 32'h55, 4'hf);
    rd_chk(ad(`DMN_IDX_CLR), 32'h55, "bad key stored");
    chk({24'h0, first_key_field}, 32'h40, "first key kept");
    rd_chk(ad(`DMN_IDX_STAT), 32'h60, "bad second flags");
    chk({31'h0, deadman_reset_req}, 32'h0, "no request yet");
    // Expiry clears the key fields and freezes at the match
    fetch(60, 1'b0);
    rd_chk(ad(`DMN_IDX_CLR), 32'h0, "second key on expiry");
    chk({24'h0, first_key_field}, 32'h0, "first key on expiry");
    chk({31'h0, deadman_reset_req}, 32'h1, "reset request");
    rd_chk(ad(`DMN_IDX_CNTL), 32'h30, "count frozen");
    // Wrong first key
    do_rst();
    key1(8'h12);
    rd_chk(ad(`DMN_IDX_STAT), 32'ha0, "bad first flags");
    // Expiry alone sets the event flag
    do_rst();
    chk({31'h0, deadman_reset_req}, 32'h0, "request after reset");
    fetch(60, 1'b0);
    rd_chk(ad(`DMN_IDX_STAT), 32'h20, "event on expiry");
    chk({31'h0, deadman_reset_req}, 32'h1, "request on expiry");
    rd_chk(ad(`DMN_IDX_CNTH), 32'h0, "count high frozen");
    chk({16'h0, held_upper_count}, 32'h0, "hold loaded");
    // Six counter reads were made; let the last strobe be counted
    @(posedge clk);
    chk(n_caps, 32'h6, "counter read captures");
    final_report();
  end
endmodule
